// ---- verilog/uec_top.sv ----
// Contract
// (RL1) set-toggle-zero strobe clears the IN endpoint data toggle.
// (RL2) set-NAK strobe sets NAK status, clear-NAK strobe clears it; write-only.
// (RL3) each IN endpoint holds a four-bit transmit FIFO select.
// (RL4) IN stall answers STALL, above endpoint NAK and global IN NAK.
// (RL5) control IN stall is cleared only by SETUP on same-numbered OUT endpoint.
// (RL6) bulk or interrupt IN stall is cleared only by software.
// (RL7) transfer type decodes control, isochronous, bulk, interrupt and steers behaviour.
// (RL8) NAK status one forces NAK; zero follows transmit FIFO state.
// (RL9) isochronous parity mismatch with current frame sends a zero-length packet.
// (RL10) bulk and interrupt toggle flips per acknowledged packet; selects DATA0/DATA1.
// (RL11) inactive endpoint ignores all tokens and gives no response.
// (RL12) IN endpoints hold an eleven-bit maximum packet length in bytes.
// (RL13) software sets enable; device clears it when finished or disabled.
// (RL14) OUT endpoint 0 disable bit is hardwired zero.
// (RL15) OUT endpoint 0 stall answers STALL above NAK; SETUP clears it.
// (RL16) snoop bit one skips CRC check on received data.
// (RL17) OUT endpoint 0 transfer type always reads control.
// (RL18) OUT endpoint 0 NAK status one forces NAK; zero follows receive FIFO.
// (RL19) OUT endpoint 0 active bit is hardwired one.
// (RL20) OUT endpoint 0 max packet code mirrors IN endpoint 0, read-only.
// (RL21) OUT endpoint 0 control resets to only the active bit set.
// (RL22) odd-frame strobe sets parity, even-frame clears; set-toggle-one sets toggle.
`timescale 1ns/1ps
`default_nettype none
module uec_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire uec_pkg::uec_token_s token_i,
  input wire uec_pkg::uec_event_s event_i,
  input wire logic global_in_nak_state_i,
  input wire logic global_out_nak_state_i,
  input wire logic frame_odd_i,
  input wire logic [uec_pkg::IN_EP_COUNT-1:0] tx_ready_i,
  input wire logic rx_space_i,
  input wire logic [uec_pkg::EP0_LEN_CODE_W-1:0] ep0_max_packet_code_i,
  output var uec_pkg::uec_resp_s resp_o
);

  localparam int N = uec_pkg::IN_EP_COUNT;

  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] wmask;
  logic [31:0] wb0;
  logic wr_take;
  logic hit_out0;
  logic [N-1:0] hit_in;
  logic [31:0] in_ctl [N];
  uec_pkg::uec_resp_e in_kind [N];
  logic [uec_pkg::FIFO_W-1:0] in_fifo [N];
  logic [uec_pkg::MAX_LEN_W-1:0] in_max_len [N];
  logic [31:0] rd_mux;
  logic o0_en_reg;
  logic o0_stall_reg;
  logic o0_snoop_reg;
  logic o0_nak_reg;
  logic [31:0] o0_ctl;
  uec_pkg::uec_resp_e o0_kind;
  uec_pkg::uec_resp_s resp_reg;
  uec_pkg::uec_resp_s resp_next;
  logic setup0;

  // byte enables gate every field, strobes included
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // a write lands only at the edge where the master sees waitrequest low
  assign wr_take = avs_write && !wait_reg;
  assign hit_out0 = (avs_address[11:2] == uec_pkg::OUT_EP0_OFFSET[11:2]);
  assign wb0 = (wr_take && hit_out0) ? (avs_writedata & wmask) : 32'h0000_0000;
  assign setup0 = token_i.valid && (token_i.pid == uec_pkg::PID_SETUP) && (token_i.ep == 2'h0);

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_in
      localparam logic [11:0] OFF = 12'(uec_pkg::IN_EP_BASE + (gi + 1) * uec_pkg::IN_EP_STRIDE);
      localparam logic [1:0] EPN = 2'(gi + 1);
      assign hit_in[gi] = (avs_address[11:2] == OFF[11:2]);
      uec_in_ep #(
        .MAX_LEN_W(uec_pkg::MAX_LEN_W),
        .FIFO_W(uec_pkg::FIFO_W)
      ) u_ep (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .wr_i(wr_take && hit_in[gi]),
        .wdata_i(avs_writedata),
        .wmask_i(wmask),
        .setup_i(token_i.valid && (token_i.pid == uec_pkg::PID_SETUP) && (token_i.ep == EPN)),
        .ack_i(event_i.valid && event_i.dir_in && (event_i.ep == EPN)),
        .done_i(event_i.valid && event_i.dir_in && (event_i.ep == EPN) && event_i.last),
        .gin_nak_i(global_in_nak_state_i),
        .frame_odd_i(frame_odd_i),
        .tx_ready_i(tx_ready_i[gi]),
        .ctl_o(in_ctl[gi]),
        .kind_o(in_kind[gi]),
        .fifo_o(in_fifo[gi]),
        .max_len_o(in_max_len[gi])
      );
    end
  endgenerate

  // OUT endpoint 0 state
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      o0_en_reg <= 1'b0;
    else if (wb0[uec_pkg::EN_BIT])
      o0_en_reg <= 1'b1; // RL13
    else if (event_i.valid && !event_i.dir_in && (event_i.ep == 2'h0) && event_i.last)
      o0_en_reg <= 1'b0; // RL13

  // software can only set it; a same-cycle SETUP loses to the set
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      o0_stall_reg <= 1'b0;
    else if (wb0[uec_pkg::STALL_BIT])
      o0_stall_reg <= 1'b1;
    else if (setup0)
      o0_stall_reg <= 1'b0; // RL15

  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      o0_nak_reg <= 1'b0;
    else if (wb0[uec_pkg::SET_NAK_BIT])
      o0_nak_reg <= 1'b1; // RL2
    else if (wb0[uec_pkg::CLR_NAK_BIT])
      o0_nak_reg <= 1'b0; // RL2

  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      o0_snoop_reg <= 1'b0;
    else if (wr_take && hit_out0 && wmask[uec_pkg::SNOOP_BIT])
      o0_snoop_reg <= avs_writedata[uec_pkg::SNOOP_BIT];

  // disable, type and active are constants here, so writes cannot move them
  always_comb
  begin
    o0_ctl = uec_pkg::OUT_EP0_RESET; // RL21 RL19
    o0_ctl[uec_pkg::DIS_BIT] = 1'b0; // RL14
    o0_ctl[uec_pkg::TYPE_LSB +: 2] = uec_pkg::TYPE_CONTROL; // RL17
    o0_ctl[uec_pkg::EN_BIT] = o0_en_reg;
    o0_ctl[uec_pkg::STALL_BIT] = o0_stall_reg;
    o0_ctl[uec_pkg::SNOOP_BIT] = o0_snoop_reg;
    o0_ctl[uec_pkg::NAK_BIT] = o0_nak_reg;
    o0_ctl[uec_pkg::EP0_LEN_CODE_W-1:0] = ep0_max_packet_code_i; // RL20
  end

  always_comb
  begin
    if (o0_stall_reg)
      o0_kind = uec_pkg::RESP_STALL; // RL15
    else if (global_out_nak_state_i || o0_nak_reg || !o0_en_reg || !rx_space_i)
      o0_kind = uec_pkg::RESP_NAK; // RL18
    else
      o0_kind = uec_pkg::RESP_ACK;
  end

  // register bus read path; unmapped words read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_out0)
      rd_mux = o0_ctl;
    for (int i = 0; i < N; i++)
      if (hit_in[i])
        rd_mux = in_ctl[i];
  end

  // every request waits exactly one cycle, then one cycle of waitrequest low
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      wait_reg <= 1'b1;
    else if (!wait_reg)
      wait_reg <= 1'b1;
    else if (avs_read || avs_write)
      wait_reg <= 1'b0;

  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      rdata_reg <= 32'h0000_0000;
    else if (wait_reg && avs_read)
      rdata_reg <= rd_mux;

  // token decode; OUT and SETUP on endpoints 1..3 belong to other logic
  always_comb
  begin
    resp_next = '0;
    resp_next.valid = token_i.valid;
    resp_next.ep = token_i.ep;
    resp_next.kind = uec_pkg::RESP_NONE;
    resp_next.crc_check = 1'b1;
    case (token_i.pid)
      uec_pkg::PID_IN:
        if (token_i.ep != 2'h0)
        begin
          resp_next.kind = in_kind[token_i.ep - 2'h1];
          resp_next.fifo = in_fifo[token_i.ep - 2'h1];
          resp_next.max_len = in_max_len[token_i.ep - 2'h1];
        end
      uec_pkg::PID_OUT:
        if (token_i.ep == 2'h0)
        begin
          resp_next.kind = o0_kind;
          resp_next.crc_check = !o0_snoop_reg; // RL16
        end
      uec_pkg::PID_SETUP:
        if (token_i.ep == 2'h0)
        begin
          resp_next.kind = uec_pkg::RESP_ACK;
          resp_next.crc_check = !o0_snoop_reg; // RL16
        end
      default:
        resp_next.kind = uec_pkg::RESP_NONE;
    endcase
    if (!token_i.valid)
      resp_next = '0;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      resp_reg <= '0;
    else
      resp_reg <= resp_next;

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign resp_o = resp_reg;

endmodule : uec_top
`default_nettype wire

// ---- verilog/uec_pkg.sv ----
package uec_pkg;

  // register map, byte addresses on the bus
  localparam logic [11:0] IN_EP_BASE = 12'h0900;
  localparam logic [11:0] IN_EP_STRIDE = 12'h0020;
  localparam logic [11:0] OUT_EP0_OFFSET = 12'h0B00;
  localparam int IN_EP_COUNT = 3;

  // values after reset
  localparam logic [31:0] IN_CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] OUT_EP0_RESET = 32'h0000_8000;

  // field positions shared by both control registers
  localparam int EN_BIT = 31;
  localparam int DIS_BIT = 30;
  localparam int SET_ONE_BIT = 29;
  localparam int SET_ZERO_BIT = 28;
  localparam int SET_NAK_BIT = 27;
  localparam int CLR_NAK_BIT = 26;
  localparam int FIFO_LSB = 22;
  localparam int FIFO_W = 4;
  localparam int STALL_BIT = 21;
  localparam int SNOOP_BIT = 20;
  localparam int TYPE_LSB = 18;
  localparam int NAK_BIT = 17;
  localparam int PARITY_BIT = 16;
  localparam int ACTIVE_BIT = 15;
  localparam int MAX_LEN_W = 11;
  localparam int EP0_LEN_CODE_W = 2;

  // transfer type encodings
  localparam logic [1:0] TYPE_CONTROL = 2'h0;
  localparam logic [1:0] TYPE_ISO = 2'h1;
  localparam logic [1:0] TYPE_BULK = 2'h2;
  localparam logic [1:0] TYPE_INTR = 2'h3;

  typedef enum logic [1:0] {PID_IN, PID_OUT, PID_SETUP} uec_pid_e;

  typedef enum logic [2:0] {
    RESP_NONE, RESP_DATA0, RESP_DATA1, RESP_ZLP, RESP_NAK, RESP_STALL, RESP_ACK
  } uec_resp_e;

  typedef struct packed {
    logic valid;
    uec_pid_e pid;
    logic [1:0] ep;
  } uec_token_s;

  // host handshake seen after a data phase; last marks the end of the transfer
  typedef struct packed {
    logic valid;
    logic dir_in;
    logic [1:0] ep;
    logic last;
  } uec_event_s;

  typedef struct packed {
    logic valid;
    uec_resp_e kind;
    logic [1:0] ep;
    logic [FIFO_W-1:0] fifo;
    logic [MAX_LEN_W-1:0] max_len;
    logic crc_check;
  } uec_resp_s;

endpackage : uec_pkg

// ---- verilog/uec_in_ep.sv ----
`timescale 1ns/1ps
`default_nettype none
module uec_in_ep #(
  parameter int MAX_LEN_W = 11,
  parameter int FIFO_W = 4
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] wmask_i,
  input wire logic setup_i,
  input wire logic ack_i,
  input wire logic done_i,
  input wire logic gin_nak_i,
  input wire logic frame_odd_i,
  input wire logic tx_ready_i,
  output logic [31:0] ctl_o,
  output uec_pkg::uec_resp_e kind_o,
  output logic [FIFO_W-1:0] fifo_o,
  output logic [MAX_LEN_W-1:0] max_len_o
);

  logic [31:0] wb;
  logic en_reg;
  logic dis_reg;
  logic stall_reg;
  logic nak_reg;
  logic pt_reg;
  logic act_reg;
  logic [1:0] type_reg;
  logic [FIFO_W-1:0] fifo_reg;
  logic [MAX_LEN_W-1:0] max_len_reg;
  logic is_ctl;
  logic toggles;

  assign wb = wr_i ? (wdata_i & wmask_i) : 32'h0000_0000;
  assign is_ctl = (type_reg == uec_pkg::TYPE_CONTROL);
  assign toggles = (type_reg == uec_pkg::TYPE_BULK) || (type_reg == uec_pkg::TYPE_INTR);

  // a software set in the same cycle as a finish keeps the endpoint enabled
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      en_reg <= 1'b0;
    else if (wb[uec_pkg::EN_BIT])
      en_reg <= 1'b1; // RL13
    else if (done_i || dis_reg)
      en_reg <= 1'b0; // RL13

  // disable is a one-cycle request; it retires together with enable
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      dis_reg <= 1'b0;
    else if (wb[uec_pkg::DIS_BIT])
      dis_reg <= 1'b1;
    else
      dis_reg <= 1'b0;

  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      stall_reg <= 1'b0;
    else if (wb[uec_pkg::STALL_BIT])
      stall_reg <= 1'b1;
    else if (is_ctl && setup_i)
      stall_reg <= 1'b0; // RL5
    else if (!is_ctl && wr_i && wmask_i[uec_pkg::STALL_BIT])
      stall_reg <= 1'b0; // RL6

  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      nak_reg <= 1'b0;
    else if (wb[uec_pkg::SET_NAK_BIT])
      nak_reg <= 1'b1; // RL2
    else if (wb[uec_pkg::CLR_NAK_BIT])
      nak_reg <= 1'b0; // RL2

  // one bit serves as frame parity for iso and as data toggle for bulk and interrupt
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      pt_reg <= 1'b0;
    else if (wb[uec_pkg::SET_ONE_BIT])
      pt_reg <= 1'b1; // RL22
    else if (wb[uec_pkg::SET_ZERO_BIT])
      pt_reg <= 1'b0; // RL1
    else if (ack_i && toggles)
      pt_reg <= ~pt_reg; // RL10

  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      act_reg <= 1'b0;
      type_reg <= uec_pkg::TYPE_CONTROL;
      fifo_reg <= '0;
      max_len_reg <= '0;
    end
    else if (wr_i)
    begin
      act_reg <= (act_reg & ~wmask_i[uec_pkg::ACTIVE_BIT])
        | (wdata_i[uec_pkg::ACTIVE_BIT] & wmask_i[uec_pkg::ACTIVE_BIT]);
      type_reg <= (type_reg & ~wmask_i[uec_pkg::TYPE_LSB +: 2])
        | (wdata_i[uec_pkg::TYPE_LSB +: 2] & wmask_i[uec_pkg::TYPE_LSB +: 2]); // RL7
      fifo_reg <= (fifo_reg & ~wmask_i[uec_pkg::FIFO_LSB +: FIFO_W])
        | (wdata_i[uec_pkg::FIFO_LSB +: FIFO_W] & wmask_i[uec_pkg::FIFO_LSB +: FIFO_W]); // RL3
      max_len_reg <= (max_len_reg & ~wmask_i[MAX_LEN_W-1:0])
        | (wdata_i[MAX_LEN_W-1:0] & wmask_i[MAX_LEN_W-1:0]); // RL12
    end

  always_comb
  begin
    ctl_o = uec_pkg::IN_CTL_RESET;
    ctl_o[uec_pkg::EN_BIT] = en_reg;
    ctl_o[uec_pkg::DIS_BIT] = dis_reg;
    ctl_o[uec_pkg::FIFO_LSB +: FIFO_W] = fifo_reg;
    ctl_o[uec_pkg::STALL_BIT] = stall_reg;
    ctl_o[uec_pkg::TYPE_LSB +: 2] = type_reg;
    ctl_o[uec_pkg::NAK_BIT] = nak_reg;
    ctl_o[uec_pkg::PARITY_BIT] = pt_reg;
    ctl_o[uec_pkg::ACTIVE_BIT] = act_reg;
    ctl_o[MAX_LEN_W-1:0] = max_len_reg;
  end

  always_comb
  begin
    if (!act_reg)
      kind_o = uec_pkg::RESP_NONE; // RL11
    else if (stall_reg)
      kind_o = uec_pkg::RESP_STALL; // RL4
    else if (gin_nak_i || nak_reg || !en_reg || !tx_ready_i)
      kind_o = uec_pkg::RESP_NAK; // RL8
    else
      case (type_reg)
        uec_pkg::TYPE_ISO:
          kind_o = (pt_reg == frame_odd_i) ? uec_pkg::RESP_DATA0 : uec_pkg::RESP_ZLP; // RL9
        uec_pkg::TYPE_BULK, uec_pkg::TYPE_INTR:
          kind_o = pt_reg ? uec_pkg::RESP_DATA1 : uec_pkg::RESP_DATA0; // RL10
        default:
          kind_o = uec_pkg::RESP_DATA0; // RL7
      endcase
  end

  assign fifo_o = fifo_reg;
  assign max_len_o = max_len_reg;

endmodule : uec_in_ep
`default_nettype wire

// ---- sim/uec_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module uec_top_monitor (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire uec_pkg::uec_token_s token_i,
  input wire logic global_in_nak_state_i,
  input wire logic global_out_nak_state_i,
  input wire logic [uec_pkg::IN_EP_COUNT-1:0] tx_ready_i,
  input wire logic rx_space_i,
  input wire logic [uec_pkg::EP0_LEN_CODE_W-1:0] ep0_max_packet_code_i,
  input wire uec_pkg::uec_resp_s resp_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_setup0;
    token_i.valid && token_i.pid == uec_pkg::PID_SETUP && token_i.ep == 2'h0 && !avs_write;
  endsequence
  sequence s_out0;
    token_i.valid && token_i.pid == uec_pkg::PID_OUT && token_i.ep == 2'h0 && !avs_write;
  endsequence
  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("bus answer wrong");
  property p_resp_pulse;
    token_i.valid |=> resp_o.valid && resp_o.ep == $past(token_i.ep);
  endproperty
  a_resp_pulse: assert property (p_resp_pulse) else $error("response missing");
  property p_resp_idle;
    !token_i.valid |=> !resp_o.valid;
  endproperty
  a_resp_idle: assert property (p_resp_idle) else $error("response without token");
  property p_setup_ack;
    s_setup0 |=> resp_o.kind == uec_pkg::RESP_ACK;
  endproperty
  a_setup_ack: assert property (p_setup_ack) else $error("setup not acked");
  property p_setup_clears;
    s_setup0 ##3 s_out0 |=> resp_o.kind != uec_pkg::RESP_STALL;
  endproperty
  a_setup_clears: assert property (p_setup_clears) else $error("stall kept");
  property p_out0_nak;
    token_i.valid && token_i.pid == uec_pkg::PID_OUT && token_i.ep == 2'h0
      && (global_out_nak_state_i || !rx_space_i)
      |=> resp_o.kind inside {uec_pkg::RESP_NAK, uec_pkg::RESP_STALL};
  endproperty
  a_out0_nak: assert property (p_out0_nak) else $error("out nak missing");
  property p_in_gate;
    token_i.valid && token_i.pid == uec_pkg::PID_IN && token_i.ep != 2'h0
      && (global_in_nak_state_i || !tx_ready_i[token_i.ep - 2'h1])
      |=> resp_o.kind inside {uec_pkg::RESP_NONE, uec_pkg::RESP_NAK, uec_pkg::RESP_STALL};
  endproperty
  a_in_gate: assert property (p_in_gate) else $error("in data while gated");
  property p_refuse;
    token_i.valid && ((token_i.pid == uec_pkg::PID_IN) == (token_i.ep == 2'h0))
      |=> resp_o.kind == uec_pkg::RESP_NONE;
  endproperty
  a_refuse: assert property (p_refuse) else $error("unserved token answered");
  property p_ep0_fixed;
    avs_read && avs_waitrequest && avs_address == uec_pkg::OUT_EP0_OFFSET
      |=> avs_readdata[15] && !avs_readdata[30] && avs_readdata[19:18] == 2'h0
      && avs_readdata[1:0] == $past(ep0_max_packet_code_i);
  endproperty
  a_ep0_fixed: assert property (p_ep0_fixed) else $error("ep0 fixed fields");
endmodule : uec_top_monitor
bind uec_top uec_top_monitor i_uec_top_monitor (.mclk_i(mclk_i), .rst_i(rst_i),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .token_i(token_i),
  .global_in_nak_state_i(global_in_nak_state_i), .global_out_nak_state_i(global_out_nak_state_i),
  .tx_ready_i(tx_ready_i), .rx_space_i(rx_space_i),
  .ep0_max_packet_code_i(ep0_max_packet_code_i), .resp_o(resp_o));
`default_nettype wire

// ---- sim/uec_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module uec_host_model (
  input wire logic mclk_i,
  input wire uec_pkg::uec_resp_s resp_i,
  output var uec_pkg::uec_token_s token_o,
  output var uec_pkg::uec_event_s event_o
);
  initial token_o = '0;
  initial event_o = '0;
  // idle fields other than the token pid show inverted values so nothing leans on a stale endpoint number
  task automatic send_token(input uec_pkg::uec_pid_e pid, input logic [1:0] ep,
    output uec_pkg::uec_resp_s seen);
    @(posedge mclk_i);
    token_o <= '{1'b1, pid, ep};
    @(posedge mclk_i);
    token_o <= '{1'b0, pid, ~ep};
    @(posedge mclk_i);
    seen = resp_i;
  endtask : send_token
  task automatic ack(input logic dir_in, input logic [1:0] ep, input logic last);
    @(posedge mclk_i);
    event_o <= '{1'b1, dir_in, ep, last};
    @(posedge mclk_i);
    event_o <= '{1'b0, ~dir_in, ~ep, ~last};
  endtask : ack
endmodule : uec_host_model
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] adr = 12'h000;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic wait_req;
  uec_pkg::uec_token_s token;
  uec_pkg::uec_event_s evt;
  uec_pkg::uec_resp_s resp;
  uec_pkg::uec_resp_s seen;
  logic gin = 1'b0;
  logic gon = 1'b0;
  logic frame_odd = 1'b0;
  logic [2:0] tx_ready = 3'h7;
  logic rx_space = 1'b1;
  logic [1:0] mpc = 2'h2;
  logic [31:0] v;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  always #12.5 mclk_i = ~mclk_i;
  uec_top i_uec_top (.mclk_i(mclk_i), .rst_i(rst_i), .avs_address(adr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .token_i(token), .event_i(evt), .global_in_nak_state_i(gin),
    .global_out_nak_state_i(gon), .frame_odd_i(frame_odd), .tx_ready_i(tx_ready),
    .rx_space_i(rx_space), .ep0_max_packet_code_i(mpc), .resp_o(resp));
  uec_host_model i_uec_host_model (.mclk_i(mclk_i), .resp_i(resp), .token_o(token),
    .event_o(evt));
  task automatic final_report();
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  always @(posedge mclk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors = errors + 1;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    adr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    do @(posedge mclk_i); while (wait_req !== 1'b0);
    v = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask : acc
  task automatic tok(input uec_pkg::uec_pid_e pid, input logic [1:0] ep,
    input uec_pkg::uec_resp_e exp);
    i_uec_host_model.send_token(pid, ep, seen);
    chk("response kind", 32'(seen.kind), 32'(exp));
  endtask : tok
  initial
  begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int i = 1; i < 4; i++)
    begin
      acc(1'b0, 12'h900 + 12'(i * 32), 32'h0);
      chk("in ep reset", v, 32'h0000_0000);
    end
    acc(1'b0, 12'hb00, 32'h0);
    chk("ep0 reset", v, 32'h0000_8002);
    acc(1'b1, 12'ha00, 32'hffff_ffff);
    acc(1'b0, 12'ha00, 32'h0);
    chk("unmapped", v, 32'h0000_0000);
    tok(uec_pkg::PID_IN, 2'h1, uec_pkg::RESP_NONE);
    tok(uec_pkg::PID_IN, 2'h0, uec_pkg::RESP_NONE);
    acc(1'b1, 12'h920, 32'h854c_87ff);
    acc(1'b0, 12'h920, 32'h0);
    chk("ep1 ctl", v, 32'h814c_87ff);
    tok(uec_pkg::PID_IN, 2'h1, uec_pkg::RESP_DATA0);
    chk("fifo", 32'(seen.fifo), 32'h0000_0005);
    chk("max len", 32'(seen.max_len), 32'h0000_07ff);
    i_uec_host_model.ack(1'b1, 2'h1, 1'b0);
    tok(uec_pkg::PID_IN, 2'h1, uec_pkg::RESP_DATA1);
    acc(1'b1, 12'h920, 32'h954c_87ff);
    tok(uec_pkg::PID_IN, 2'h1, uec_pkg::RESP_DATA0);
    acc(1'b1, 12'h920, 32'ha54c_87ff);
    tok(uec_pkg::PID_IN, 2'h1, uec_pkg::RESP_DATA1);
    acc(1'b1, 12'h920, 32'h894c_87ff);
    tok(uec_pkg::PID_IN, 2'h1, uec_pkg::RESP_NAK);
    acc(1'b0, 12'h920, 32'h0);
    chk("nak status", v & 32'h0002_0000, 32'h0002_0000);
    acc(1'b1, 12'h920, 32'h8168_87ff);
    gin <= 1'b1;
    tok(uec_pkg::PID_IN, 2'h1, uec_pkg::RESP_STALL);
    tok(uec_pkg::PID_SETUP, 2'h0, uec_pkg::RESP_ACK);
    tok(uec_pkg::PID_IN, 2'h1, uec_pkg::RESP_STALL);
    acc(1'b1, 12'h920, 32'h8548_87ff);
    tok(uec_pkg::PID_IN, 2'h1, uec_pkg::RESP_NAK);
    gin <= 1'b0;
    tok(uec_pkg::PID_IN, 2'h1, uec_pkg::RESP_DATA1);
    i_uec_host_model.ack(1'b1, 2'h1, 1'b1);
    acc(1'b0, 12'h920, 32'h0);
    chk("enable", v & 32'h8000_0000, 32'h0000_0000);
    tok(uec_pkg::PID_IN, 2'h1, uec_pkg::RESP_NAK);
    acc(1'b1, 12'h940, 32'h8420_8000);
    tok(uec_pkg::PID_IN, 2'h2, uec_pkg::RESP_STALL);
    acc(1'b1, 12'h940, 32'h8000_8000);
    tok(uec_pkg::PID_IN, 2'h2, uec_pkg::RESP_STALL);
    tok(uec_pkg::PID_SETUP, 2'h2, uec_pkg::RESP_NONE);
    tok(uec_pkg::PID_IN, 2'h2, uec_pkg::RESP_DATA0);
    acc(1'b1, 12'h960, 32'h9404_8000);
    tok(uec_pkg::PID_IN, 2'h3, uec_pkg::RESP_DATA0);
    frame_odd <= 1'b1;
    tok(uec_pkg::PID_IN, 2'h3, uec_pkg::RESP_ZLP);
    acc(1'b1, 12'h960, 32'ha004_8000);
    tok(uec_pkg::PID_IN, 2'h3, uec_pkg::RESP_DATA0);
    tx_ready <= 3'h3;
    tok(uec_pkg::PID_IN, 2'h3, uec_pkg::RESP_NAK);
    acc(1'b1, 12'hb00, 32'hffff_ffff);
    acc(1'b0, 12'hb00, 32'h0);
    chk("ep0 ctl", v, 32'h8032_8002);
    tok(uec_pkg::PID_OUT, 2'h0, uec_pkg::RESP_STALL);
    tok(uec_pkg::PID_SETUP, 2'h0, uec_pkg::RESP_ACK);
    chk("crc check", 32'(seen.crc_check), 32'h0000_0000);
    tok(uec_pkg::PID_OUT, 2'h0, uec_pkg::RESP_NAK);
    acc(1'b1, 12'hb00, 32'h8400_0000);
    tok(uec_pkg::PID_OUT, 2'h0, uec_pkg::RESP_ACK);
    chk("crc check", 32'(seen.crc_check), 32'h0000_0001);
    gon <= 1'b1;
    tok(uec_pkg::PID_OUT, 2'h0, uec_pkg::RESP_NAK);
    gon <= 1'b0;
    rx_space <= 1'b0;
    mpc <= 2'h1;
    tok(uec_pkg::PID_OUT, 2'h0, uec_pkg::RESP_NAK);
    acc(1'b0, 12'hb00, 32'h0);
    chk("ep0 code", v & 32'h0000_0003, 32'h0000_0001);
    final_report();
  end
endmodule : testbench
`default_nettype wire
